// *** rter_bank.sv ***
// Task trigger and event flag register bank of a radio controller, APB slave.
// Assumes the radio datapath gives one-cycle event pulses on pclk.
module rter_bank (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ramp_done_evt,
	input wire logic address_done_evt,
	input wire logic payload_done_evt,
	input wire logic packet_done_evt,
	output logic tx_enable_trigger,
	output logic rx_enable_trigger,
	output logic start_trigger,
	output logic stop_trigger,
	output logic disable_trigger,
	output logic signal_strength_start_trigger,
	output logic signal_strength_stop_trigger,
	output logic bit_counter_start_trigger,
	output logic bit_counter_stop_trigger,
	output logic energy_detect_start_trigger,
	output logic energy_detect_stop_trigger,
	output logic channel_assess_start_trigger,
	output logic channel_assess_stop_trigger,
	output logic irq
);
	localparam int nt = rter_pkg::num_tasks;
	localparam int ne = rter_pkg::num_events;

	typedef struct packed {
		rter_pkg::rter_bus_state_t st;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [ne-1:0] flag;
		logic [ne-1:0] mask;
		logic irq;
	} rter_bank_state_t;

	rter_bank_state_t q;
	rter_bank_state_t next_q;
	logic [nt-1:0] task_hit;
	logic [ne-1:0] evt_hit;
	logic [ne-1:0] evt_in;
	logic [nt-1:0] pulse;
	logic wr_take;
	logic wr_one;
	logic [ne-1:0] flag_set;
	logic [ne-1:0] flag_clr;

	// Task offset lookup by index
	function automatic logic [11:0] task_off(input int i);
		case (i)
			rter_pkg::t_tx_enable: task_off = rter_pkg::off_tx_enable;
			rter_pkg::t_rx_enable: task_off = rter_pkg::off_rx_enable;
			rter_pkg::t_start: task_off = rter_pkg::off_start;
			rter_pkg::t_stop: task_off = rter_pkg::off_stop;
			rter_pkg::t_disable: task_off = rter_pkg::off_disable;
			rter_pkg::t_ss_start: task_off = rter_pkg::off_ss_start;
			rter_pkg::t_ss_stop: task_off = rter_pkg::off_ss_stop;
			rter_pkg::t_bc_start: task_off = rter_pkg::off_bc_start;
			rter_pkg::t_bc_stop: task_off = rter_pkg::off_bc_stop;
			rter_pkg::t_ed_start: task_off = rter_pkg::off_ed_start;
			rter_pkg::t_ed_stop: task_off = rter_pkg::off_ed_stop;
			rter_pkg::t_cca_start: task_off = rter_pkg::off_cca_start;
			default: task_off = rter_pkg::off_cca_stop;
		endcase
	endfunction : task_off

	function automatic logic [11:0] evt_off(input int i);
		case (i)
			0: evt_off = rter_pkg::off_ramp_done;
			1: evt_off = rter_pkg::off_address_done;
			2: evt_off = rter_pkg::off_payload_done;
			default: evt_off = rter_pkg::off_packet_done;
		endcase
	endfunction : evt_off

	generate
		for (genvar i = 0; i < nt; i++) begin : g_task
			assign task_hit[i] = (paddr == task_off(i));
		end
		for (genvar j = 0; j < ne; j++) begin : g_evt
			assign evt_hit[j] = (paddr == evt_off(j));
		end
	endgenerate

	assign evt_in = {packet_done_evt, payload_done_evt, address_done_evt, ramp_done_evt};
	// Writes take effect in the access cycle, answered with zero wait
	assign wr_take = psel && penable && pwrite && (q.st == rter_pkg::rter_access);
	assign wr_one = wr_take && pwdata[rter_pkg::task_bit];

	rter_task_pulser #(
		.n(nt)
	) u_pulser (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.hit(task_hit),
		.wr_one(wr_one),
		.pulse(pulse)
	);

	always_comb begin
		next_q = q;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;
		flag_clr = '0;
		flag_set = evt_in;
		case (q.st)
			rter_pkg::rter_idle: begin
				if (psel && !penable) begin
					next_q.st = rter_pkg::rter_access;
					next_q.pready = 1'b1;
					next_q.pslverr = !((|task_hit) || (|evt_hit)
						|| paddr == rter_pkg::off_int_mask
						|| paddr == rter_pkg::off_int_status);
					next_q.prdata = 32'h00000000;
					if (!pwrite) begin
						for (int k = 0; k < ne; k++) begin
							if (evt_hit[k]) begin
								next_q.prdata = {31'h00000000, q.flag[k]};
							end
						end
						if (paddr == rter_pkg::off_int_mask) begin
							next_q.prdata = {28'h0000000, q.mask};
						end
						if (paddr == rter_pkg::off_int_status) begin
							next_q.prdata = {28'h0000000, q.flag};
						end
					end
				end
			end
			rter_pkg::rter_access: begin
				next_q.st = rter_pkg::rter_idle;
				if (wr_take) begin
					for (int k = 0; k < ne; k++) begin
						// Flag registers take the written bit
						if (evt_hit[k] && !pwdata[rter_pkg::task_bit]) begin
							flag_clr[k] = 1'b1;
						end
						if (evt_hit[k] && pwdata[rter_pkg::task_bit]) begin
							flag_set[k] = 1'b1;
						end
					end
					if (paddr == rter_pkg::off_int_mask) begin
						next_q.mask = pwdata[ne-1:0];
					end
					if (paddr == rter_pkg::off_int_status) begin
						flag_clr = flag_clr | pwdata[ne-1:0];
					end
				end
			end
			default: next_q.st = rter_pkg::rter_idle;
		endcase
		// Hardware set beats a software clear
		next_q.flag = (q.flag & ~flag_clr) | flag_set;
		next_q.irq = |(next_q.flag & next_q.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.st <= rter_pkg::rter_idle;
			q.prdata <= rter_pkg::flag_reset;
			q.pready <= 1'b0;
			q.pslverr <= 1'b0;
			q.flag <= '0;
			q.mask <= rter_pkg::mask_reset;
			q.irq <= 1'b0;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign irq = q.irq;
	assign tx_enable_trigger = pulse[rter_pkg::t_tx_enable];
	assign rx_enable_trigger = pulse[rter_pkg::t_rx_enable];
	assign start_trigger = pulse[rter_pkg::t_start];
	assign stop_trigger = pulse[rter_pkg::t_stop];
	assign disable_trigger = pulse[rter_pkg::t_disable];
	assign signal_strength_start_trigger = pulse[rter_pkg::t_ss_start];
	assign signal_strength_stop_trigger = pulse[rter_pkg::t_ss_stop];
	assign bit_counter_start_trigger = pulse[rter_pkg::t_bc_start];
	assign bit_counter_stop_trigger = pulse[rter_pkg::t_bc_stop];
	assign energy_detect_start_trigger = pulse[rter_pkg::t_ed_start];
	assign energy_detect_stop_trigger = pulse[rter_pkg::t_ed_stop];
	assign channel_assess_start_trigger = pulse[rter_pkg::t_cca_start];
	assign channel_assess_stop_trigger = pulse[rter_pkg::t_cca_stop];

	property p_rx_trig;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_rx_enable && pwdata[0]) |=> rx_enable_trigger;
	endproperty
	a_rx_trig: assert property (p_rx_trig) else $error("rx trigger missing");

	property p_rx_zero;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_rx_enable && !pwdata[0]) |=> !rx_enable_trigger;
	endproperty
	a_rx_zero: assert property (p_rx_zero) else $error("zero write triggered");

	property p_start_trig;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_start && pwdata[0]) |=> start_trigger;
	endproperty
	a_start_trig: assert property (p_start_trig) else $error("start trigger missing");

	property p_ss_once;
		@(posedge pclk) disable iff (!presetn)
		(ce && signal_strength_start_trigger) |=> !signal_strength_start_trigger;
	endproperty
	a_ss_once: assert property (p_ss_once) else $error("sample trigger repeated");

	property p_bc_stop;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_bc_stop && pwdata[0]) |=> bit_counter_stop_trigger;
	endproperty
	a_bc_stop: assert property (p_bc_stop) else $error("bit stop missing");

	property p_cca_stop;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_cca_stop && pwdata[0]) |=> channel_assess_stop_trigger;
	endproperty
	a_cca_stop: assert property (p_cca_stop) else $error("cca stop missing");

	property p_ready_set;
		@(posedge pclk) disable iff (!presetn)
		(ce && ramp_done_evt) |=> q.flag[0];
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("ramp flag not set");

	property p_end_irq;
		@(posedge pclk) disable iff (!presetn)
		(ce && packet_done_evt && q.mask[3]
			&& !(wr_take && paddr == rter_pkg::off_int_mask)) |=> irq;
	endproperty
	a_end_irq: assert property (p_end_irq) else $error("packet irq missing");

	property p_tx_trig;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_tx_enable && pwdata[0]) |=> tx_enable_trigger;
	endproperty
	a_tx_trig: assert property (p_tx_trig) else $error("tx trigger missing");

	property p_stop_trig;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_stop && pwdata[0])
			|=> stop_trigger;
	endproperty
	a_stop_trig: assert property (p_stop_trig) else $error("stop trigger missing");

	property p_dis_trig;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_disable && pwdata[0])
			|=> disable_trigger;
	endproperty
	a_dis_trig: assert property (p_dis_trig) else $error("disable trigger missing");

	property p_ss_start;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_ss_start && pwdata[0])
			|=> signal_strength_start_trigger;
	endproperty
	a_ss_start: assert property (p_ss_start) else $error("sample start missing");

	property p_ss_stop;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_ss_stop && pwdata[0])
			|=> signal_strength_stop_trigger;
	endproperty
	a_ss_stop: assert property (p_ss_stop) else $error("sample stop missing");

	property p_bc_start;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_bc_start && pwdata[0])
			|=> bit_counter_start_trigger;
	endproperty
	a_bc_start: assert property (p_bc_start) else $error("bit start missing");

	property p_ed_start;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_ed_start && pwdata[0])
			|=> energy_detect_start_trigger;
	endproperty
	a_ed_start: assert property (p_ed_start) else $error("energy start missing");

	property p_ed_stop;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_ed_stop && pwdata[0])
			|=> energy_detect_stop_trigger;
	endproperty
	a_ed_stop: assert property (p_ed_stop) else $error("energy stop missing");

	property p_cca_start;
		@(posedge pclk) disable iff (!presetn)
		(ce && wr_take && paddr == rter_pkg::off_cca_start && pwdata[0])
			|=> channel_assess_start_trigger;
	endproperty
	a_cca_start: assert property (p_cca_start) else $error("cca start missing");

	property p_addr_set;
		@(posedge pclk) disable iff (!presetn)
		(ce && address_done_evt) |=> q.flag[1];
	endproperty
	a_addr_set: assert property (p_addr_set) else $error("address flag not set");

	property p_pay_set;
		@(posedge pclk) disable iff (!presetn)
		(ce && payload_done_evt) |=> q.flag[2];
	endproperty
	a_pay_set: assert property (p_pay_set) else $error("payload flag not set");

	property p_end_set;
		@(posedge pclk) disable iff (!presetn)
		(ce && packet_done_evt) |=> q.flag[3];
	endproperty
	a_end_set: assert property (p_end_set) else $error("packet flag not set");

	property p_no_spur;
		@(posedge pclk) disable iff (!presetn)
		(ce && !wr_one) |=> (pulse == '0);
	endproperty
	a_no_spur: assert property (p_no_spur) else $error("trigger without write");
endmodule : rter_bank

// *** rter_pkg.sv ***
// Package for the radio task and event register bank.
// Assumes a single peripheral clock; shared by the bank and its trigger pulser.
package rter_pkg;
	localparam int addr_w = 12;
	localparam logic [11:0] off_tx_enable = 12'h000;
	localparam logic [11:0] off_rx_enable = 12'h004;
	localparam logic [11:0] off_start = 12'h008;
	localparam logic [11:0] off_stop = 12'h00c;
	localparam logic [11:0] off_disable = 12'h010;
	localparam logic [11:0] off_ss_start = 12'h014;
	localparam logic [11:0] off_ss_stop = 12'h018;
	localparam logic [11:0] off_bc_start = 12'h01c;
	localparam logic [11:0] off_bc_stop = 12'h020;
	localparam logic [11:0] off_ed_start = 12'h024;
	localparam logic [11:0] off_ed_stop = 12'h028;
	localparam logic [11:0] off_cca_start = 12'h02c;
	localparam logic [11:0] off_cca_stop = 12'h030;
	localparam logic [11:0] off_ramp_done = 12'h100;
	localparam logic [11:0] off_address_done = 12'h104;
	localparam logic [11:0] off_payload_done = 12'h108;
	localparam logic [11:0] off_packet_done = 12'h10c;
	localparam logic [11:0] off_int_mask = 12'h300;
	localparam logic [11:0] off_int_status = 12'h304;
	localparam int num_tasks = 13;
	localparam int num_events = 4;
	localparam int task_bit = 0;
	localparam logic [3:0] mask_reset = 4'h0;
	localparam logic [31:0] flag_reset = 32'h00000000;
	// Task indices, ordered by offset
	localparam int t_tx_enable = 0;
	localparam int t_rx_enable = 1;
	localparam int t_start = 2;
	localparam int t_stop = 3;
	localparam int t_disable = 4;
	localparam int t_ss_start = 5;
	localparam int t_ss_stop = 6;
	localparam int t_bc_start = 7;
	localparam int t_bc_stop = 8;
	localparam int t_ed_start = 9;
	localparam int t_ed_stop = 10;
	localparam int t_cca_start = 11;
	localparam int t_cca_stop = 12;
	typedef enum logic [1:0] {
		rter_idle = 2'b00,
		rter_access = 2'b01
	} rter_bus_state_t;
endpackage : rter_pkg

// *** rter_task_pulser.sv ***
// Turns accepted task writes into one-cycle trigger pulses.
// Assumes the writer presents a decoded one-hot strobe in the write cycle.
module rter_task_pulser #(
	parameter int n = 13
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [n-1:0] hit,
	input wire logic wr_one,
	output logic [n-1:0] pulse
);
	typedef struct packed {
		logic [n-1:0] pulse;
	} rter_pulse_state_t;
	rter_pulse_state_t q;
	rter_pulse_state_t next_q;

	always_comb begin
		next_q = q;
		// Zero writes leave the trigger untouched
		next_q.pulse = wr_one ? hit : '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else if (ce) begin
			q <= next_q;
		end
	end

	assign pulse = q.pulse;
endmodule : rter_task_pulser

// *** radio_task_event_regs_tb.sv ***
// Self-checking bench for the radio task and event register bank.
// Assumes rter_bank answers APB within twenty cycles and pulses triggers one cycle.
module radio_task_event_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk;
	logic presetn;
	logic ce;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] evt;
	wire [12:0] trig;
	logic [31:0] tv;
	logic irq;
	int bad_count;
	int total_checks;
	assign tv = {19'h0, trig};

	rter_bank u_dut (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.ramp_done_evt(evt[0]), .address_done_evt(evt[1]),
		.payload_done_evt(evt[2]), .packet_done_evt(evt[3]),
		.tx_enable_trigger(trig[rter_pkg::t_tx_enable]),
		.rx_enable_trigger(trig[rter_pkg::t_rx_enable]),
		.start_trigger(trig[rter_pkg::t_start]),
		.stop_trigger(trig[rter_pkg::t_stop]),
		.disable_trigger(trig[rter_pkg::t_disable]),
		.signal_strength_start_trigger(trig[rter_pkg::t_ss_start]),
		.signal_strength_stop_trigger(trig[rter_pkg::t_ss_stop]),
		.bit_counter_start_trigger(trig[rter_pkg::t_bc_start]),
		.bit_counter_stop_trigger(trig[rter_pkg::t_bc_stop]),
		.energy_detect_start_trigger(trig[rter_pkg::t_ed_start]),
		.energy_detect_stop_trigger(trig[rter_pkg::t_ed_stop]),
		.channel_assess_start_trigger(trig[rter_pkg::t_cca_start]),
		.channel_assess_stop_trigger(trig[rter_pkg::t_cca_stop]),
		.irq(irq)
	);

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Leaves the request up so a following call continues back to back
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			bad_count++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
	endtask : apb

	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : idle

	task automatic pulse(input int k);
		evt[k] <= 1'b1;
		@(posedge pclk);
		evt <= 4'h0;
	endtask : pulse

	task automatic t_reset();
		logic [31:0] rd;
		logic err;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, 12'h100 + 12'(k * 4), 32'h0, rd, err);
			check(rd, 32'h0);
			check({31'h0, err}, 32'h0);
		end
		apb(1'b0, 12'h300, 32'h0, rd, err);
		idle();
		check(rd, 32'h0);
		check({31'h0, irq}, 32'h0);
		check(tv, 32'h0);
	endtask : t_reset

	task automatic t_triggers();
		logic [31:0] rd;
		logic err;
		logic [31:0] oh;
		for (int i = 0; i < rter_pkg::num_tasks; i++) begin
			oh = 32'h1 << i;
			apb(1'b1, 12'(i * 4), 32'h00000001, rd, err);
			idle();
			check(tv, oh);
			@(posedge pclk);
			check(tv, 32'h0);
			apb(1'b1, 12'(i * 4), 32'hfffffffe, rd, err);
			idle();
			check(tv, 32'h0);
			@(posedge pclk);
			check(tv, 32'h0);
			apb(1'b0, 12'(i * 4), 32'h0, rd, err);
			idle();
			check(rd, 32'h0);
		end
	endtask : t_triggers

	task automatic t_flags();
		logic [31:0] rd;
		logic err;
		for (int k = 0; k < 4; k++) begin
			pulse(k);
			apb(1'b0, 12'h100 + 12'(k * 4), 32'h0, rd, err);
			check(rd, 32'h1);
			apb(1'b1, 12'h100 + 12'(k * 4), 32'h0, rd, err);
			apb(1'b0, 12'h100 + 12'(k * 4), 32'h0, rd, err);
			check(rd, 32'h0);
			apb(1'b1, 12'h100 + 12'(k * 4), 32'h1, rd, err);
			apb(1'b0, 12'h100 + 12'(k * 4), 32'h0, rd, err);
			check(rd, 32'h1);
			apb(1'b1, 12'h100 + 12'(k * 4), 32'h0, rd, err);
			idle();
		end
	endtask : t_flags

	task automatic t_irq();
		logic [31:0] rd;
		logic err;
		apb(1'b1, 12'h300, 32'h5, rd, err);
		idle();
		pulse(1);
		@(posedge pclk);
		check({31'h0, irq}, 32'h0);
		pulse(2);
		@(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(1'b0, 12'h304, 32'h0, rd, err);
		check(rd, 32'h6);
		apb(1'b1, 12'h304, 32'h4, rd, err);
		apb(1'b0, 12'h304, 32'h0, rd, err);
		idle();
		check(rd, 32'h2);
		check({31'h0, irq}, 32'h0);
		apb(1'b0, 12'h200, 32'h0, rd, err);
		idle();
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask : t_irq

	// Frozen clock enable drops an event; a mid-run reset clears flags and mask
	task automatic t_freeze();
		logic [31:0] rd;
		logic err;
		ce <= 1'b0;
		evt[0] <= 1'b1;
		@(posedge pclk);
		ce <= 1'b1;
		evt <= 4'h0;
		apb(1'b0, 12'h100, 32'h0, rd, err);
		idle();
		check(rd, 32'h0);
		pulse(0);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h304, 32'h0, rd, err);
		check(rd, 32'h0);
		apb(1'b0, 12'h300, 32'h0, rd, err);
		idle();
		check(rd, 32'h0);
		check({31'h0, irq}, 32'h0);
	endtask : t_freeze

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		evt = 4'h0;
		bad_count = 0;
		total_checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_triggers();
		t_flags();
		t_irq();
		t_freeze();
		give_verdict();
	end
endmodule : radio_task_event_regs_tb
